// ---- hdl/ipdp_pkg.sv ----
// shared constants and types for the interrupt pacing, dma pointer and power-down registers
`default_nettype none
package ipdp_pkg;
  localparam int ADDR_W = 10;
  localparam logic [9:0] OFF_PACE = 10'h340;
  localparam logic [9:0] OFF_DMA = 10'h344;
  localparam logic [9:0] OFF_PWR = 10'h354;

  localparam int SPACE_HI = 31;
  localparam int SPACE_LO = 24;
  localparam int WIDTH_HI = 15;
  localparam int WIDTH_LO = 0;
  localparam int DMA_HI = 15;
  localparam int DMA_LO = 0;
  localparam int CNT_HI = 31;
  localparam int CNT_LO = 16;

  localparam int UFRAME_US = 125;
  localparam logic [31:0] PACE_RST = 32'h0000_000F;
  localparam logic [31:0] DMA_RST = 32'h0000_0000;
  localparam logic [31:0] PWR_RST = 32'h03E8_1BA0;
  localparam logic [15:0] CNT_RST16 = 16'h17E8;
  localparam logic [15:0] CNT_FIX16 = 16'h1400;

  // power-down control, low half
  typedef struct packed {
    logic [2:0] rsvd_15_13;
    logic third_port_pulldown;
    logic second_port_pulldown;
    logic battery_detector_power;
    logic [3:0] rsvd_9_6;
    logic bias_circuit_enable;
    logic regulator_keep_on;
    logic third_overcurrent_power;
    logic second_overcurrent_power;
    logic first_overcurrent_power;
    logic controller_clock_gate;
  } ipdp_pwr_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PULSE = 2'b01,
    ST_GAP = 2'b11
  } ipdp_state_e;
endpackage
`default_nettype wire

// ---- hdl/ipdp_regs.sv ----
// edge interrupt pacing, dma start pointer and power-down control registers
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - edge mode: successive pulses at least programmed microframes apart, field bits 31:24
// - spacing zero: no gap; events arriving during a pulse merge into one pulse that follows it
// - level mode: spacing setting has no effect
// - edge pulse lasts exactly the programmed cycles, field bits 15:0
// - reset: pulse width 15, spacing 0
// - dma start register low 16 bits give the dma memory start address
// - dma start register is write-only, reset zero, upper half reserved
// - power-down control read/write at 0354h, counter in upper half, gating bits
// - pacing register read/write at 0340h, all bits accessible
// - clock-off counter sets awake time after wake-up; zero disables wake-up
// - 16-bit bus: counter defaults 17E8h, any write fixes it at 1400h
// - port pull-down bit 1 connects, 0 disconnects the resistors
// - battery detector bit 0 keeps it powered in suspend, 1 powers down
module ipdp_regs (
  // clock, reset and 16-bit bus mode
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus16_mode_i,
  // processor bus
  input wire logic [ipdp_pkg::ADDR_W-1:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  // interrupt shaping
  input wire logic edge_mode_i,
  input wire logic irq_event_i,
  input wire logic irq_level_i,
  input wire logic uframe_tick_i,
  output logic irq_o,
  // dma and power control
  output logic [15:0] dma_start_addr_o,
  output logic [15:0] clk_off_count_o,
  output logic wake_enable_o,
  output logic third_port_pulldown_o,
  output logic second_port_pulldown_o,
  output logic battery_detector_power_o,
  output logic bias_circuit_enable_o,
  output logic regulator_keep_on_o,
  output logic third_overcurrent_power_o,
  output logic second_overcurrent_power_o,
  output logic first_overcurrent_power_o,
  output logic controller_clock_gate_o
);
  logic [31:0] pace_r;
  // only the meaningful low half is stored; the reserved upper half never reaches logic
  logic [15:0] dma_r;
  logic [15:0] cnt_r;
  ipdp_pkg::ipdp_pwr_s pwr_r;
  logic [31:0] rdata_r;
  ipdp_pkg::ipdp_state_e state_r, state_nxt;
  logic [15:0] width_cnt_r, width_cnt_nxt;
  logic [7:0] gap_cnt_r, gap_cnt_nxt;
  logic pending_r;
  logic pulse_r;

  wire sel_pace = bus_addr_i == ipdp_pkg::OFF_PACE;
  wire sel_dma = bus_addr_i == ipdp_pkg::OFF_DMA;
  wire sel_pwr = bus_addr_i == ipdp_pkg::OFF_PWR;
  wire wr_pace = bus_wr_i && sel_pace;
  wire wr_dma = bus_wr_i && sel_dma;
  wire wr_pwr = bus_wr_i && sel_pwr;
  wire [7:0] min_space = pace_r[ipdp_pkg::SPACE_HI:ipdp_pkg::SPACE_LO];
  wire [15:0] pulse_cycles = pace_r[ipdp_pkg::WIDTH_HI:ipdp_pkg::WIDTH_LO];
  // the dma register is write-only, so it answers reads with zero
  wire [31:0] rd_mux = sel_pace ? pace_r :
                       sel_pwr ? {cnt_r, pwr_r} : 32'h0000_0000;
  wire [15:0] cnt_wr = bus16_mode_i ? ipdp_pkg::CNT_FIX16 :
                       bus_wdata_i[ipdp_pkg::CNT_HI:ipdp_pkg::CNT_LO];
  wire want = pending_r || irq_event_i;
  wire start = edge_mode_i && want && (pulse_cycles != 16'h0000);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pace_r <= ipdp_pkg::PACE_RST;
      dma_r <= ipdp_pkg::DMA_RST[ipdp_pkg::DMA_HI:ipdp_pkg::DMA_LO];
      pwr_r <= ipdp_pkg::PWR_RST[ipdp_pkg::CNT_LO-1:0];
      cnt_r <= bus16_mode_i ? ipdp_pkg::CNT_RST16 :
               ipdp_pkg::PWR_RST[ipdp_pkg::CNT_HI:ipdp_pkg::CNT_LO];
    end
    else
    begin
      if (wr_pace)
        pace_r <= bus_wdata_i;
      if (wr_dma)
        dma_r <= bus_wdata_i[ipdp_pkg::DMA_HI:ipdp_pkg::DMA_LO];
      if (wr_pwr)
      begin
        pwr_r <= bus_wdata_i[ipdp_pkg::CNT_LO-1:0];
        cnt_r <= cnt_wr;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_r <= 32'h0000_0000;
    else if (bus_rd_i)
      rdata_r <= rd_mux;
  end

  // pulse sequencer: width counts clocks, gap counts microframe ticks after the pulse
  always_comb
  begin
    state_nxt = state_r;
    width_cnt_nxt = width_cnt_r;
    gap_cnt_nxt = gap_cnt_r;
    case (state_r)
      ipdp_pkg::ST_IDLE:
      begin
        if (start)
        begin
          state_nxt = ipdp_pkg::ST_PULSE;
          width_cnt_nxt = pulse_cycles;
        end
      end
      ipdp_pkg::ST_PULSE:
      begin
        width_cnt_nxt = width_cnt_r - 16'h0001;
        if (width_cnt_r == 16'h0001)
        begin
          if (min_space != 8'h00)
          begin
            state_nxt = ipdp_pkg::ST_GAP;
            gap_cnt_nxt = min_space;
          end
          else
            state_nxt = ipdp_pkg::ST_IDLE;
        end
      end
      ipdp_pkg::ST_GAP:
      begin
        if (!edge_mode_i)
          state_nxt = ipdp_pkg::ST_IDLE;
        else if (uframe_tick_i)
        begin
          gap_cnt_nxt = gap_cnt_r - 8'h01;
          if (gap_cnt_r == 8'h01)
            state_nxt = ipdp_pkg::ST_IDLE;
        end
      end
      default:
        state_nxt = ipdp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ipdp_pkg::ST_IDLE;
      width_cnt_r <= 16'h0000;
      gap_cnt_r <= 8'h00;
      pending_r <= 1'b0;
      pulse_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      width_cnt_r <= width_cnt_nxt;
      gap_cnt_r <= gap_cnt_nxt;
      pulse_r <= state_nxt == ipdp_pkg::ST_PULSE;
      // an event arriving while a pulse or gap is running is kept, not lost
      if (!edge_mode_i)
        pending_r <= 1'b0;
      else if (state_r == ipdp_pkg::ST_IDLE && start)
        pending_r <= 1'b0;
      else if (irq_event_i && state_r != ipdp_pkg::ST_IDLE)
        pending_r <= 1'b1;
    end
  end

  // level mode bypasses the pacing entirely
  assign irq_o = edge_mode_i ? pulse_r : irq_level_i;
  assign bus_rdata_o = rdata_r;
  assign dma_start_addr_o = dma_r;
  assign clk_off_count_o = cnt_r;
  assign wake_enable_o = cnt_r != 16'h0000;
  assign third_port_pulldown_o = pwr_r.third_port_pulldown;
  assign second_port_pulldown_o = pwr_r.second_port_pulldown;
  assign battery_detector_power_o = pwr_r.battery_detector_power;
  assign bias_circuit_enable_o = pwr_r.bias_circuit_enable;
  assign regulator_keep_on_o = pwr_r.regulator_keep_on;
  assign third_overcurrent_power_o = pwr_r.third_overcurrent_power;
  assign second_overcurrent_power_o = pwr_r.second_overcurrent_power;
  assign first_overcurrent_power_o = pwr_r.first_overcurrent_power;
  assign controller_clock_gate_o = pwr_r.controller_clock_gate;

  // helper: measured high time against the width loaded at pulse start
  logic [15:0] hi_cnt_r;
  logic [15:0] width_at_start_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hi_cnt_r <= 16'h0000;
      width_at_start_r <= 16'h0000;
    end
    else
    begin
      hi_cnt_r <= pulse_r ? hi_cnt_r + 16'h0001 : 16'h0000;
      if (state_r == ipdp_pkg::ST_IDLE && start)
        width_at_start_r <= pulse_cycles;
    end
  end

  property p_width;
    @(posedge clk_i) disable iff (rst_i)
    $fell(pulse_r) |-> hi_cnt_r == width_at_start_r;
  endproperty
  a_width: assert property (p_width) else $error("pulse width mismatch");

  property p_no_gap;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ipdp_pkg::ST_IDLE && start) |=> irq_o;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("pulse not started at once");

  property p_gap_quiet;
    @(posedge clk_i) disable iff (rst_i)
    (edge_mode_i && state_r == ipdp_pkg::ST_GAP) |-> !irq_o;
  endproperty
  a_gap_quiet: assert property (p_gap_quiet) else $error("pulse inside spacing gap");

  property p_gap_end;
    @(posedge clk_i) disable iff (rst_i)
    (edge_mode_i && state_r == ipdp_pkg::ST_GAP && uframe_tick_i && gap_cnt_r == 8'h01)
      |=> state_r == ipdp_pkg::ST_IDLE;
  endproperty
  a_gap_end: assert property (p_gap_end) else $error("gap did not end");

  property p_level;
    @(posedge clk_i) disable iff (rst_i)
    !edge_mode_i |-> irq_o == irq_level_i;
  endproperty
  a_level: assert property (p_level) else $error("level mode altered");

  property p_reset;
    @(posedge clk_i)
    rst_i |=> (pace_r == ipdp_pkg::PACE_RST &&
               dma_r == ipdp_pkg::DMA_RST[ipdp_pkg::DMA_HI:ipdp_pkg::DMA_LO]);
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset value");

  property p_dma;
    @(posedge clk_i) disable iff (rst_i)
    wr_dma |=> dma_start_addr_o == $past(bus_wdata_i[ipdp_pkg::DMA_HI:ipdp_pkg::DMA_LO]);
  endproperty
  a_dma: assert property (p_dma) else $error("dma address not taken");

  property p_wo;
    @(posedge clk_i) disable iff (rst_i)
    (bus_rd_i && sel_dma) |=> bus_rdata_o == 32'h0000_0000;
  endproperty
  a_wo: assert property (p_wo) else $error("write-only register read back");

  property p_fix16;
    @(posedge clk_i) disable iff (rst_i)
    (wr_pwr && bus16_mode_i) |=> clk_off_count_o == ipdp_pkg::CNT_FIX16;
  endproperty
  a_fix16: assert property (p_fix16) else $error("counter not fixed in 16-bit mode");

  property p_pend;
    @(posedge clk_i) disable iff (rst_i)
    (edge_mode_i && irq_event_i && state_r != ipdp_pkg::ST_IDLE) |=> pending_r;
  endproperty
  a_pend: assert property (p_pend) else $error("event lost during pulse");

  property p_pace_rw;
    @(posedge clk_i) disable iff (rst_i)
    wr_pace ##1 !bus_wr_i ##1 (bus_rd_i && sel_pace && !bus_wr_i)
      |=> bus_rdata_o == $past(bus_wdata_i, 3);
  endproperty
  a_pace_rw: assert property (p_pace_rw) else $error("pacing read-back wrong");

  c_pulse: cover property (@(posedge clk_i) disable iff (rst_i) $fell(pulse_r));
  c_gap: cover property (@(posedge clk_i) disable iff (rst_i)
    state_r == ipdp_pkg::ST_GAP ##1 state_r == ipdp_pkg::ST_IDLE);
  c_pend: cover property (@(posedge clk_i) disable iff (rst_i) pending_r && start);
endmodule // ipdp_regs
`default_nettype wire

// ---- testbench/ipdp_host_model.sv ----
// host processor model driving the register strobe bus
`timescale 1ns/1ns
`default_nettype none
module ipdp_host_model (
  // clock
  input wire logic clk_i,
  // register bus
  output logic [9:0] bus_addr_o,
  output logic bus_wr_o,
  output logic bus_rd_o,
  output logic [31:0] bus_wdata_o,
  input wire logic [31:0] bus_rdata_i
);
  initial
  begin
    bus_addr_o = 10'h000;
    bus_wr_o = 1'b0;
    bus_rd_o = 1'b0;
    bus_wdata_o = 32'h0000_0000;
  end

  // software never stores anything but reset values in reserved places
  function automatic logic [31:0] fix(input logic [9:0] a, input logic [31:0] d);
    case (a)
      10'h340: fix = d & 32'hFF00_FFFF;
      10'h344: fix = d & 32'h0000_FFFF;
      10'h354: fix = (d & 32'hFFFF_1C3F) | 32'h0000_0380;
      default: fix = d;
    endcase
  endfunction

  // released lines show the inverse so stale values cannot look valid
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_addr_o <= a;
    bus_wdata_o <= fix(a, d);
    bus_wr_o <= 1'b1;
    @(posedge clk_i);
    bus_wr_o <= 1'b0;
    bus_addr_o <= ~a;
    bus_wdata_o <= ~fix(a, d);
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus_addr_o <= a;
    bus_rd_o <= 1'b1;
    @(posedge clk_i);
    bus_rd_o <= 1'b0;
    bus_addr_o <= ~a;
    @(posedge clk_i);
    d = bus_rdata_i;
  endtask
endmodule // ipdp_host_model
`default_nettype wire

// ---- testbench/tb_irq_pacing_dma_power_regs.sv ----
// self-checking bench for the pacing, dma pointer and power-down registers
`timescale 1ns/1ns
`default_nettype none
module tb_irq_pacing_dma_power_regs;
  typedef struct {logic [9:0] a; logic [31:0] d; logic [31:0] q;} ipdp_row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus16_mode_i = 1'b0;
  logic edge_mode_i = 1'b1;
  logic irq_event_i = 1'b0;
  logic irq_level_i = 1'b0;
  logic uframe_tick_i = 1'b0;
  logic [4:0] tcnt = 5'h00;
  logic [9:0] bus_addr_i;
  logic bus_wr_i, bus_rd_i, irq_o, wake_enable_o;
  logic [31:0] bus_wdata_i, bus_rdata_o, q;
  logic [15:0] dma_start_addr_o, clk_off_count_o;
  logic p3, p2, bat, bias, vreg, oc3, oc2, oc1, gate;
  int checks = 0;
  int err_total = 0;
  int tk, hi;
  ipdp_row_s rows [6] = '{
    '{10'h340, 32'h0300_0002, 32'h0300_0002},
    '{10'h340, 32'hFF12_0009, 32'hFF00_0009},
    '{10'h344, 32'h5A5A_ABCD, 32'h0000_0000},
    '{10'h354, 32'h0000_043F, 32'h0000_07BF},
    '{10'h354, 32'h1400_1800, 32'h1400_1B80},
    '{10'h348, 32'h1234_5678, 32'h0000_0000}};
  // power outputs rebuilt into register layout, reserved fields at reset values
  wire logic [31:0] pwr_view = {clk_off_count_o, 3'h0, p3, p2, bat, 4'hE,
    bias, vreg, oc3, oc2, oc1, gate};

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    tcnt <= (tcnt == 5'h13) ? 5'h00 : tcnt + 5'h01;
    uframe_tick_i <= (tcnt == 5'h13);
  end

  ipdp_host_model ipdp_host_model_inst (.clk_i(clk_i), .bus_addr_o(bus_addr_i),
    .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i), .bus_wdata_o(bus_wdata_i),
    .bus_rdata_i(bus_rdata_o));

  ipdp_regs ipdp_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .bus16_mode_i(bus16_mode_i),
    .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .edge_mode_i(edge_mode_i),
    .irq_event_i(irq_event_i), .irq_level_i(irq_level_i), .uframe_tick_i(uframe_tick_i),
    .irq_o(irq_o), .dma_start_addr_o(dma_start_addr_o), .clk_off_count_o(clk_off_count_o),
    .wake_enable_o(wake_enable_o), .third_port_pulldown_o(p3), .second_port_pulldown_o(p2),
    .battery_detector_power_o(bat), .bias_circuit_enable_o(bias),
    .regulator_keep_on_o(vreg), .third_overcurrent_power_o(oc3),
    .second_overcurrent_power_o(oc2), .first_overcurrent_power_o(oc1),
    .controller_clock_gate_o(gate));

  task automatic end_sim();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // event held high for n cycles, each high cycle is one event
  task automatic fire(input int n);
    @(posedge clk_i);
    irq_event_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    irq_event_i <= 1'b0;
  endtask

  // ticks seen while low, then high cycles of the next pulse
  // sampling starts at a falling edge so a pulse launched on the preceding rising edge is seen settled
  task automatic pulse(output int t, output int h);
    int n;
    t = 0;
    h = 0;
    @(negedge clk_i);
    for (n = 0; n < 400 && irq_o !== 1'b1; n++)
    begin
      if (uframe_tick_i === 1'b1)
        t++;
      @(negedge clk_i);
    end
    for (; n < 400 && irq_o === 1'b1; n++)
    begin
      h++;
      @(negedge clk_i);
    end
    if (n >= 400)
    begin
      err_total++;
      end_sim();
    end
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    ipdp_host_model_inst.rd(10'h340, q);
    chk(q, 32'h0000_000F);
    ipdp_host_model_inst.rd(10'h344, q);
    chk(q, 32'h0000_0000);
    chk(pwr_view, 32'h03E8_1BA0);
    for (int i = 0; i < 6; i++)
    begin
      ipdp_host_model_inst.wr(rows[i].a, rows[i].d);
      ipdp_host_model_inst.rd(rows[i].a, q);
      chk(q, rows[i].q);
      if (rows[i].a == 10'h344)
        chk(dma_start_addr_o, rows[i].d[15:0]);
      if (rows[i].a == 10'h354)
        chk(pwr_view, rows[i].q);
      if (rows[i].a == 10'h354)
        chk(wake_enable_o, rows[i].q[31:16] != 16'h0000);
    end
    ipdp_host_model_inst.wr(10'h340, 32'h0000_0003);
    fire(1);
    pulse(tk, hi);
    chk(hi, 3);
    fire(2);
    pulse(tk, hi);
    pulse(tk, hi);
    chk(hi, 3);
    ipdp_host_model_inst.wr(10'h340, 32'h0200_0003);
    fire(4);
    pulse(tk, hi);
    chk(tk, 2);
    chk(hi, 3);
    @(posedge clk_i);
    edge_mode_i <= 1'b0;
    irq_level_i <= 1'b1;
    fire(3);
    chk(irq_o, 1'b1);
    irq_level_i <= 1'b0;
    fire(2);
    chk(irq_o, 1'b0);
    edge_mode_i <= 1'b1;
    bus16_mode_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    ipdp_host_model_inst.rd(10'h354, q);
    chk(q, 32'h17E8_1BA0);
    ipdp_host_model_inst.wr(10'h354, 32'hABCD_1BA0);
    @(negedge clk_i);
    chk(clk_off_count_o, 16'h1400);
    ipdp_host_model_inst.rd(10'h354, q);
    chk(q, 32'h1400_1BA0);
    ipdp_host_model_inst.wr(10'h340, 32'h0000_0000);
    fire(1);
    repeat (3) @(negedge clk_i);
    chk(irq_o, 1'b0);
    end_sim();
  end
endmodule // tb_irq_pacing_dma_power_regs
`default_nettype wire
